// ### logic/cgr_bank.sv
// top: indexed block register bank of the clock generator
`timescale 1ns/1ps
`default_nettype none
module cgr_bank
	import cgr_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic frame_start,
	input wire logic frame_read,
	input wire logic [5:0] start_index,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire logic rd_ready,
	output logic rd_valid,
	output logic [7:0] rd_data,
	input wire logic straps_valid_n,
	input wire logic freq_select_b,
	input wire logic freq_select_c,
	input wire logic clock_request0_n,
	input wire logic clock_request1_n,
	input wire logic clock_request2_n,
	input wire logic clock_halt_request_n,
	output logic [2:0] proc_out_en,
	output logic [2:0] serial_ref_pair_en,
	output logic video_96mhz_pair_en,
	output logic panel_clock_pair_en,
	output logic ref_out_en,
	output logic [1:0] ref_edge_rate,
	output logic main_spread_on,
	output logic panel_spread_on,
	output logic [2:0] panel_spread_select,
	output logic [8:0] proc_divider_active,
	output logic [7:0] panel_divider_active
);
	cgr_if rf ();
	cgr_state_t state;
	logic [5:0] index;
	logic [5:0] remaining;
	logic [5:0] byte_count;
	logic [7:0] reserved_six;
	logic [7:0] reserved_seven;
	logic [7:0] reserved_eight;
	logic [1:0] straps;
	logic straps_taken;
	logic reset_load;
	logic [7:0] status_readback;
	logic rd_pending;
	logic write_take;
	logic read_take;

	function automatic logic [7:0] read_mux(input logic [5:0] a, input logic [7:0] status, input logic [5:0] cnt,
			input logic [7:0] r6, input logic [7:0] r7, input logic [7:0] r8, input logic [7:0] sp,
			input logic [7:0] oe, input logic [7:0] oc, input logic [8:0] pd, input logic [7:0] pn,
			input logic [7:0] pe);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADDR_SPREAD_CONTROL: v = sp;
			ADDR_OUTPUT_ENABLES: v = oe;
			ADDR_OUTPUT_CONTROL: v = oc;
			ADDR_PROC_DIVIDER_HIGH: v = {RST_PROC_DIVIDER_HIGH[7:1], pd[8]};
			ADDR_PROC_DIVIDER_LOW: v = pd[7:0];
			ADDR_RESERVED_SIX: v = r6;
			ADDR_RESERVED_SEVEN: v = r7;
			ADDR_RESERVED_EIGHT: v = r8;
			ADDR_PANEL_DIVIDER: v = pn;
			ADDR_STATUS_READBACK: v = status;
			ADDR_REVISION_VENDOR_ID: v = {REVISION_CODE, VENDOR_CODE};
			ADDR_BYTE_COUNT: v = {2'b00, cnt};
			ADDR_PROGRAM_ENABLE: v = pe;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	assign rf.clock_halt_request_n = clock_halt_request_n;
	assign status_readback = {straps, clock_request0_n, clock_request1_n, clock_request2_n, 3'b000};

	// straps are caught once, on the first clock with the strobe low after reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			straps <= 2'b00;
			straps_taken <= 1'b0;
		end else if (!straps_taken && !straps_valid_n) begin
			straps <= {freq_select_b, freq_select_c};
			straps_taken <= 1'b1;
		end
	end
	assign reset_load = !straps_taken && !straps_valid_n;

	// frame sequencer: index from start, then count byte on writes, then data
	assign write_take = wr_valid && (state == CGR_DATA) && !frame_read && (remaining != 6'h00);
	assign read_take = rd_valid && rd_ready;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= CGR_IDLE;
			index <= 6'h00;
			remaining <= 6'h00;
		end else if (frame_start) begin
			state <= frame_read ? CGR_DATA : CGR_COUNT;
			index <= start_index;
			remaining <= 6'h00;
		end else begin
			case (state)
				CGR_IDLE: begin
					state <= CGR_IDLE;
				end
				CGR_COUNT: begin
					if (wr_valid) begin
						remaining <= wr_data[5:0];
						state <= CGR_DATA;
					end
				end
				CGR_DATA: begin
					if (write_take || (read_take && !rd_pending)) begin
						index <= index + 6'h01;
						remaining <= remaining - 6'h01;
					end else if (read_take && rd_pending) begin
						// count byte taken: the data bytes still owed on this read
						remaining <= byte_count;
					end
				end
				default: state <= CGR_IDLE;
			endcase
		end
	end

	// read stream: first the byte count, then count bytes from the index
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			rd_pending <= 1'b0;
		end else if (frame_start && frame_read) begin
			rd_valid <= 1'b1;
			rd_data <= {2'b00, byte_count};
			rd_pending <= 1'b1;
		end else if (read_take) begin
			if (rd_pending) begin
				rd_pending <= 1'b0;
				rd_valid <= (byte_count != 6'h00);
				rd_data <= read_mux(index, status_readback, byte_count, reserved_six, reserved_seven, reserved_eight,
					rf.spread_control, rf.output_enables, rf.output_control, rf.proc_divider, rf.panel_divider,
					rf.program_enable);
			end else begin
				rd_valid <= (remaining > 6'h01);
				rd_data <= read_mux(index + 6'h01, status_readback, byte_count, reserved_six, reserved_seven,
					reserved_eight, rf.spread_control, rf.output_enables, rf.output_control, rf.proc_divider,
					rf.panel_divider, rf.program_enable);
			end
		end
	end

	// strap-selected divider default, shared by the register and the applied value
	logic [8:0] proc_default;
	assign proc_default = {1'b0, ({freq_select_c, freq_select_b} == STRAP_SEL_166) ? DIV_DEFAULT_166 : DIV_DEFAULT_OTHER};

	// writable registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rf.spread_control <= RST_SPREAD_CONTROL;
			rf.output_enables <= RST_OUTPUT_ENABLES;
			rf.output_control <= RST_OUTPUT_CONTROL;
			rf.program_enable <= RST_PROGRAM_ENABLE;
			byte_count <= RST_BYTE_COUNT;
		end else if (write_take) begin
			case (index)
				ADDR_SPREAD_CONTROL: rf.spread_control <= {wr_data[7:3], 3'b000};
				ADDR_OUTPUT_ENABLES: rf.output_enables <= wr_data;
				ADDR_OUTPUT_CONTROL: begin
					// reserved slew code is refused so the pad never sees it
					if (wr_data[FLD_REF_SLEW_LSB +: 2] == SLEW_RESERVED) begin
						rf.output_control <= {2'b00, wr_data[5], rf.output_control[4:3], wr_data[2:0]};
					end else begin
						rf.output_control <= {2'b00, wr_data[5:0]};
					end
				end
				ADDR_BYTE_COUNT: byte_count <= wr_data[5:0];
				ADDR_PROGRAM_ENABLE: rf.program_enable <= {6'h00, wr_data[1:0]};
				default: ;
			endcase
		end
	end

	// reserved bytes keep their reset values; writes are ignored and only the read path sees them
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reserved_six <= RST_RESERVED_SIX;
			reserved_seven <= RST_RESERVED_SEVEN;
			reserved_eight <= RST_RESERVED_EIGHT;
		end else begin
			reserved_six <= RST_RESERVED_SIX;
			reserved_seven <= RST_RESERVED_SEVEN;
			reserved_eight <= RST_RESERVED_EIGHT;
		end
	end

	// processor divider: strap-based default, then host writes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rf.proc_divider <= {1'b0, DIV_DEFAULT_OTHER};
		end else if (reset_load) begin
			rf.proc_divider <= proc_default;
		end else if (write_take && index == ADDR_PROC_DIVIDER_HIGH) begin
			rf.proc_divider[8] <= wr_data[0];
		end else if (write_take && index == ADDR_PROC_DIVIDER_LOW) begin
			rf.proc_divider[7:0] <= wr_data;
		end
	end

	// panel divider is read-only to the host; it keeps its default
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rf.panel_divider <= RST_PANEL_DIVIDER;
		end else begin
			rf.panel_divider <= RST_PANEL_DIVIDER;
		end
	end

	cgr_output_gate u_gate (
		.clock(clock),
		.arst_n(arst_n),
		.rf(rf.gate)
	);

	cgr_divider_load u_divs (
		.clock(clock),
		.arst_n(arst_n),
		.proc_divider_reset(proc_default),
		.reset_load(reset_load),
		.rf(rf.divs)
	);

	assign proc_out_en = rf.proc_out_en;
	// pair 0 sits on the highest bit, as for the processor pairs
	assign serial_ref_pair_en = {rf.serial_video_panel_en[2], rf.serial_video_panel_en[3], rf.serial_video_panel_en[4]};
	assign video_96mhz_pair_en = rf.serial_video_panel_en[1];
	assign panel_clock_pair_en = rf.serial_video_panel_en[0];
	assign ref_out_en = rf.ref_out_en;
	assign ref_edge_rate = rf.ref_edge_rate;
	assign main_spread_on = rf.main_spread_on;
	assign panel_spread_on = rf.panel_spread_on;
	assign panel_spread_select = rf.panel_spread_select;
	assign proc_divider_active = rf.proc_divider_active;
	assign panel_divider_active = rf.panel_divider_active;
endmodule : cgr_bank
`default_nettype wire

// ### logic/cgr_divider_load.sv
// divider staging: programmed values reach the synthesizers only while programming is enabled
`timescale 1ns/1ps
`default_nettype none
module cgr_divider_load
	import cgr_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [8:0] proc_divider_reset,
	input wire logic reset_load,
	cgr_if.divs rf
);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rf.proc_divider_active <= {1'b0, DIV_DEFAULT_OTHER};
		end else if (reset_load) begin
			rf.proc_divider_active <= proc_divider_reset;
		end else if (rf.program_enable[BIT_PROC_PROG_EN]) begin
			rf.proc_divider_active <= rf.proc_divider;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rf.panel_divider_active <= RST_PANEL_DIVIDER;
		end else if (rf.program_enable[BIT_PANEL_PROG_EN]) begin
			// panel frequency = 4 MHz * value / 4
			rf.panel_divider_active <= rf.panel_divider;
		end
	end
endmodule : cgr_divider_load
`default_nettype wire

// ### logic/cgr_if.sv
// interface: register file view shared between the bank and its helpers
`timescale 1ns/1ps
`default_nettype none
interface cgr_if;
	logic [7:0] spread_control;
	logic [7:0] output_enables;
	logic [7:0] output_control;
	logic [8:0] proc_divider;
	logic [7:0] panel_divider;
	logic [7:0] program_enable;
	logic clock_halt_request_n;
	logic [2:0] proc_out_en;
	logic [5:0] serial_video_panel_en;
	logic ref_out_en;
	logic [1:0] ref_edge_rate;
	logic main_spread_on;
	logic panel_spread_on;
	logic [2:0] panel_spread_select;
	logic [8:0] proc_divider_active;
	logic [7:0] panel_divider_active;
	modport bank (output spread_control, output_enables, output_control, output proc_divider, output panel_divider,
		output program_enable, output clock_halt_request_n, input proc_out_en, input serial_video_panel_en,
		input ref_out_en, input ref_edge_rate, input main_spread_on, input panel_spread_on, input panel_spread_select,
		input proc_divider_active, input panel_divider_active);
	modport gate (input spread_control, output_enables, output_control, clock_halt_request_n,
		output proc_out_en, serial_video_panel_en, ref_out_en, ref_edge_rate, main_spread_on, panel_spread_on,
		panel_spread_select);
	modport divs (input proc_divider, panel_divider, program_enable, output proc_divider_active, panel_divider_active);
endinterface : cgr_if
`default_nettype wire

// ### logic/cgr_output_gate.sv
// output qualification: buffer enables, halt gating and spread controls
`timescale 1ns/1ps
`default_nettype none
module cgr_output_gate
	import cgr_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	cgr_if.gate rf
);
	logic halt_active;
	assign halt_active = !rf.clock_halt_request_n;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rf.proc_out_en <= 3'h7;
		end else begin
			// bits 7..5 -> pairs 0..2, stop qualifiers bits 2..0 -> pairs 0..2
			for (int i = 0; i < 3; i++) begin
				rf.proc_out_en[i] <= rf.output_enables[7 - i] && !(halt_active && rf.output_control[2 - i]);
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rf.serial_video_panel_en <= 6'h3f;
			rf.ref_out_en <= 1'b1;
			rf.ref_edge_rate <= 2'b10;
		end else begin
			rf.serial_video_panel_en <= rf.output_enables[5:0];
			rf.ref_out_en <= rf.output_control[BIT_REF_EN];
			rf.ref_edge_rate <= rf.output_control[FLD_REF_SLEW_LSB +: 2];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rf.main_spread_on <= 1'b1;
			rf.panel_spread_on <= 1'b1;
			rf.panel_spread_select <= 3'h0;
		end else begin
			rf.main_spread_on <= rf.spread_control[BIT_MAIN_SPREAD_EN];
			rf.panel_spread_on <= rf.spread_control[BIT_PANEL_SPREAD_EN];
			// select has no effect while panel spread is off
			if (rf.spread_control[BIT_PANEL_SPREAD_EN]) begin
				rf.panel_spread_select <= rf.spread_control[FLD_PANEL_SEL_LSB +: 3];
			end
		end
	end
endmodule : cgr_output_gate
`default_nettype wire

// ### logic/cgr_pkg.sv
// package: register map, field positions and reset values of the clock generator control bank
package cgr_pkg;
	localparam logic [5:0] ADDR_SPREAD_CONTROL = 6'h01;
	localparam logic [5:0] ADDR_OUTPUT_ENABLES = 6'h02;
	localparam logic [5:0] ADDR_OUTPUT_CONTROL = 6'h03;
	localparam logic [5:0] ADDR_PROC_DIVIDER_HIGH = 6'h04;
	localparam logic [5:0] ADDR_PROC_DIVIDER_LOW = 6'h05;
	localparam logic [5:0] ADDR_RESERVED_SIX = 6'h06;
	localparam logic [5:0] ADDR_RESERVED_SEVEN = 6'h07;
	localparam logic [5:0] ADDR_RESERVED_EIGHT = 6'h08;
	localparam logic [5:0] ADDR_PANEL_DIVIDER = 6'h09;
	localparam logic [5:0] ADDR_STATUS_READBACK = 6'h0a;
	localparam logic [5:0] ADDR_REVISION_VENDOR_ID = 6'h0b;
	localparam logic [5:0] ADDR_BYTE_COUNT = 6'h0f;
	localparam logic [5:0] ADDR_PROGRAM_ENABLE = 6'h29;

	localparam logic [7:0] RST_SPREAD_CONTROL = 8'hc0;
	localparam logic [7:0] RST_OUTPUT_ENABLES = 8'hff;
	localparam logic [7:0] RST_OUTPUT_CONTROL = 8'h30;
	localparam logic [7:0] RST_PROC_DIVIDER_HIGH = 8'h5e;
	localparam logic [7:0] RST_RESERVED_SIX = 8'hf3;
	localparam logic [7:0] RST_RESERVED_SEVEN = 8'h00;
	localparam logic [7:0] RST_RESERVED_EIGHT = 8'h00;
	localparam logic [7:0] RST_PANEL_DIVIDER = 8'h96;
	localparam logic [5:0] RST_BYTE_COUNT = 6'h0f;
	localparam logic [7:0] RST_PROGRAM_ENABLE = 8'h00;

	localparam logic [7:0] DIV_DEFAULT_166 = 8'h7d;
	localparam logic [7:0] DIV_DEFAULT_OTHER = 8'h64;
	// straps c,b = 0,1 select the 166 MHz processor clock
	localparam logic [1:0] STRAP_SEL_166 = 2'b01;

	localparam int BIT_MAIN_SPREAD_EN = 7;
	localparam int BIT_PANEL_SPREAD_EN = 6;
	localparam int FLD_PANEL_SEL_LSB = 3;
	localparam int BIT_REF_EN = 5;
	localparam int FLD_REF_SLEW_LSB = 3;
	localparam int BIT_PROC_PROG_EN = 1;
	localparam int BIT_PANEL_PROG_EN = 0;
	localparam logic [1:0] SLEW_RESERVED = 2'b11;

	// arbitrary neutral identity nibbles
	localparam logic [3:0] REVISION_CODE = 4'h0;
	localparam logic [3:0] VENDOR_CODE = 4'h0;

	typedef enum logic [1:0] {
		CGR_IDLE = 2'b00,
		CGR_COUNT = 2'b01,
		CGR_DATA = 2'b10
	} cgr_state_t;
endpackage : cgr_pkg

// ### sim/cgr_bank_asserts.sv
// checker: port-level properties of the control register bank
`timescale 1ns/1ps
`default_nettype none
module cgr_bank_asserts
	import cgr_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic frame_start,
	input wire logic frame_read,
	input wire logic wr_valid,
	input wire logic rd_ready,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	input wire logic straps_valid_n,
	input wire logic clock_halt_request_n,
	input wire logic [2:0] proc_out_en,
	input wire logic [2:0] serial_ref_pair_en,
	input wire logic video_96mhz_pair_en,
	input wire logic panel_clock_pair_en,
	input wire logic ref_out_en,
	input wire logic [1:0] ref_edge_rate,
	input wire logic main_spread_on,
	input wire logic panel_spread_on,
	input wire logic [8:0] proc_divider_active,
	input wire logic [7:0] panel_divider_active
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
		else $error("read byte dropped before taken");
	read_answer_a: assert property (frame_start && frame_read |=> rd_valid)
		else $error("no count byte after read start");
	write_quiet_a: assert property (frame_start && !frame_read |=> !rd_valid)
		else $error("read byte during write frame");
	slew_legal_a: assert property (ref_edge_rate != SLEW_RESERVED)
		else $error("reserved edge rate applied");
	panel_fixed_a: assert property (panel_divider_active == RST_PANEL_DIVIDER)
		else $error("panel divider moved");
	reset_ctl_a: assert property ($rose(arst_n) |-> ref_out_en && ref_edge_rate == 2'b10 && main_spread_on)
		else $error("control outputs wrong after reset");
	reset_oe_a: assert property ($rose(arst_n) |-> &{proc_out_en, serial_ref_pair_en, video_96mhz_pair_en,
		panel_clock_pair_en, panel_spread_on})
		else $error("enables wrong after reset");
	div_quiet_a: assert property ((!wr_valid && !straps_valid_n) [*4] |=> $stable(proc_divider_active))
		else $error("divider changed without a write");
	halt_no_raise_a: assert property ($fell(clock_halt_request_n) && !wr_valid |=> ##1
		(proc_out_en & ~$past(proc_out_en, 2)) == 3'b000)
		else $error("halt request enabled a pair");
endmodule // cgr_bank_asserts
bind cgr_bank cgr_bank_asserts chk (.clock, .arst_n, .frame_start, .frame_read, .wr_valid, .rd_ready, .rd_valid,
	.rd_data, .straps_valid_n, .clock_halt_request_n, .proc_out_en, .serial_ref_pair_en, .video_96mhz_pair_en,
	.panel_clock_pair_en, .ref_out_en, .ref_edge_rate, .main_spread_on, .panel_spread_on, .proc_divider_active,
	.panel_divider_active);
`default_nettype wire

// ### sim/cgr_bank_tb_top.sv
// testbench: random and corner traffic through the control register bank
`timescale 1ns/1ps
`default_nettype none
module cgr_bank_tb_top;
	import cgr_pkg::*;
	logic clock = 0;
	logic arst_n = 0;
	logic straps_valid_n = 1;
	logic freq_select_b, freq_select_c, b_l, c_l, bsy;
	logic clock_request0_n = 1, clock_request1_n = 1, clock_request2_n = 1, clock_halt_request_n = 1;
	logic frame_start, frame_read, wr_valid, rd_ready, rd_valid;
	logic video_96mhz_pair_en, panel_clock_pair_en, ref_out_en, main_spread_on, panel_spread_on;
	logic [5:0] start_index;
	logic [7:0] wr_data, rd_data, panel_divider_active;
	logic [2:0] proc_out_en, serial_ref_pair_en, panel_spread_select;
	logic [1:0] ref_edge_rate;
	logic [8:0] proc_divider_active, act;
	logic [7:0] m [1:9];
	int bad_count = 0, n_checks = 0, cyc = 0, n, cnt;
	always #12.5 clock = ~clock;
	cgr_bank uut (.clock, .arst_n, .frame_start, .frame_read, .start_index, .wr_valid, .wr_data, .rd_ready,
		.rd_valid, .rd_data, .straps_valid_n, .freq_select_b, .freq_select_c, .clock_request0_n, .clock_request1_n,
		.clock_request2_n, .clock_halt_request_n, .proc_out_en, .serial_ref_pair_en, .video_96mhz_pair_en,
		.panel_clock_pair_en, .ref_out_en, .ref_edge_rate, .main_spread_on, .panel_spread_on, .panel_spread_select,
		.proc_divider_active, .panel_divider_active);
	cgr_host u_host (.clock, .frame_start, .frame_read, .start_index, .wr_valid, .wr_data, .rd_ready, .rd_valid,
		.rd_data);
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 12000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_pins(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [7:0] reg_exp(input int i);
		if (i == 10) return {b_l, c_l, clock_request0_n, clock_request1_n, clock_request2_n, 3'b000};
		if (i == 11) return {REVISION_CODE, VENDOR_CODE};
		return m[i];
	endfunction
	function automatic logic [15:0] pins_exp();
		logic [2:0] stop;
		stop = clock_halt_request_n ? 3'b000 : {m[3][0], m[3][1], m[3][2]};
		return {3'b000, {m[2][5], m[2][6], m[2][7]} & ~stop, m[2][2], m[2][3], m[2][4], m[2][1:0], m[3][5:3], m[1][7:6]};
	endfunction
	task automatic apply(input int i, input logic [7:0] d);
		case (i)
			1: m[1] = {d[7:3], 3'b000};
			2, 5: m[i] = d;
			3: m[3] = {2'b00, d[5], (d[4:3] == SLEW_RESERVED) ? m[3][4:3] : d[4:3], d[2:0]};
			4: m[4] = {RST_PROC_DIVIDER_HIGH[7:1], d[0]};
			default: ;
		endcase
	endtask
	task automatic wr(input logic [5:0] a, input int c, input int nsend);
		u_host.write_block(a, 8'(c), nsend);
		for (int k = 0; k < c; k++) apply(a + k, u_host.wbuf[k]);
		repeat (3) @(posedge clock);
	endtask
	task automatic check_outputs();
		chk_pins("outputs", pins_exp(), {3'b000, proc_out_en, serial_ref_pair_en, video_96mhz_pair_en,
			panel_clock_pair_en, ref_out_en, ref_edge_rate, main_spread_on, panel_spread_on});
		if (panel_spread_on === 1'b1) chk_byte("spread select", {5'b0, m[1][5:3]}, {5'b0, panel_spread_select});
	endtask
	task automatic rd_check(input int c);
		u_host.read_block(6'h01, bsy);
		chk_pins("read finished", 16'h0000, 16'(bsy));
		chk_pins("bytes read", 16'(c), 16'(u_host.rcnt));
		chk_byte("byte count", 8'(c), u_host.rbuf[0]);
		for (int i = 1; i <= 11 && i <= c; i++) chk_byte($sformatf("reg %0d", i), reg_exp(i), u_host.rbuf[i]);
	endtask
	initial begin
		void'($urandom(32'he170));
		{freq_select_c, freq_select_b} = 2'($urandom);
		repeat (12) @(posedge clock);
		#1 arst_n = 1;
		{c_l, b_l} = {freq_select_c, freq_select_b};
		m = '{RST_SPREAD_CONTROL, RST_OUTPUT_ENABLES, RST_OUTPUT_CONTROL, RST_PROC_DIVIDER_HIGH, DIV_DEFAULT_OTHER,
			RST_RESERVED_SIX, RST_RESERVED_SEVEN, RST_RESERVED_EIGHT, RST_PANEL_DIVIDER};
		if ({c_l, b_l} == STRAP_SEL_166) m[5] = DIV_DEFAULT_166;
		@(posedge clock) #1 straps_valid_n = 0;
		repeat (4) @(posedge clock);
		check_outputs();
		chk_pins("divider default", 16'({1'b0, m[5]}), 16'(proc_divider_active));
		rd_check(15);
		$display("test reset done");
		repeat (24) begin
			n = $urandom_range(11, 1);
			cnt = $urandom_range(12 - n, 1);
			for (int k = 0; k < 16; k++) u_host.wbuf[k] = 8'($urandom);
			u_host.slow = 1'($urandom);
			wr(6'(n), cnt, cnt + ($urandom_range(3) == 0));
			check_outputs();
			rd_check(15);
			{clock_halt_request_n, clock_request0_n, clock_request1_n, clock_request2_n} = 4'($urandom);
			{freq_select_b, freq_select_c} = 2'($urandom);
			repeat (4) @(posedge clock);
			check_outputs();
		end
		$display("test random done");
		u_host.wbuf[0] = 8'h05;
		wr(ADDR_BYTE_COUNT, 1, 1);
		rd_check(5);
		u_host.wbuf[0] = 8'(RST_BYTE_COUNT);
		wr(ADDR_BYTE_COUNT, 1, 1);
		rd_check(15);
		$display("test count done");
		act = proc_divider_active;
		u_host.wbuf[0] = 8'($urandom);
		u_host.wbuf[1] = 8'($urandom);
		wr(ADDR_PROC_DIVIDER_HIGH, 2, 2);
		chk_pins("divider held", 16'(act), 16'(proc_divider_active));
		u_host.wbuf[0] = 8'h64;
		wr(ADDR_PANEL_DIVIDER, 1, 1);
		u_host.wbuf[0] = 8'h03;
		wr(ADDR_PROGRAM_ENABLE, 1, 1);
		chk_pins("divider loaded", 16'({m[4][0], m[5]}), 16'(proc_divider_active));
		chk_byte("panel divider", RST_PANEL_DIVIDER, panel_divider_active);
		rd_check(15);
		$display("test divider done");
		complete_run();
	end
endmodule // cgr_bank_tb_top
`default_nettype wire

// ### sim/cgr_host.sv
// partner: host controller model issuing indexed block transfers
`timescale 1ns/1ps
`default_nettype none
module cgr_host (
	input wire logic clock,
	output logic frame_start,
	output logic frame_read,
	output logic [5:0] start_index,
	output logic wr_valid,
	output logic [7:0] wr_data,
	output logic rd_ready,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data
);
	logic [7:0] wbuf [0:15];
	logic [7:0] rbuf [0:64];
	int rcnt;
	bit slow;
	initial begin
		{frame_start, frame_read, wr_valid, rd_ready} = 4'h0;
		start_index = 6'h00;
		wr_data = 8'h00;
	end
	// nsend above cnt only when a test wants surplus bytes
	task automatic write_block(input logic [5:0] n, input logic [7:0] cnt, input int nsend);
		@(posedge clock) #1;
		frame_start = 1'b1;
		frame_read = 1'b0;
		start_index = n;
		@(posedge clock) #1;
		frame_start = 1'b0;
		start_index = ~n;
		wr_valid = 1'b1;
		wr_data = cnt;
		for (int k = 0; k < nsend; k++) begin
			@(posedge clock) #1;
			wr_data = wbuf[k];
		end
		@(posedge clock) #1;
		wr_valid = 1'b0;
		wr_data = ~wr_data; // released bus shows no stale byte
	endtask
	task automatic read_block(input logic [5:0] n, output bit err);
		int w;
		int k;
		w = 0;
		k = 0;
		@(posedge clock) #1;
		frame_start = 1'b1;
		frame_read = 1'b1;
		start_index = n;
		@(posedge clock) #1;
		frame_start = 1'b0;
		start_index = ~n;
		rd_ready = !slow || $urandom_range(2) != 0;
		while ((k == 0 || k <= rbuf[0]) && w < 300) begin
			@(posedge clock);
			if (rd_valid && rd_ready) begin
				rbuf[k] = rd_data;
				k++;
			end
			#1 rd_ready = (k == 0 || k <= rbuf[0]) && (!slow || $urandom_range(2) != 0);
			w++;
		end
		rcnt = k - 1;
		err = w >= 300;
	endtask
endmodule // cgr_host
`default_nettype wire
